//--- core/eros_pkg.sv
/*
 Constants, field layouts and carrier types of the E1 receive overhead
 and synchronisation monitor.
 Assumes a framer on the same clock that supplies bit positions and
 basic frame, CRC and signalling multiframe counters.
*/
// Behaviour
// - Basic frame loss forces CRC multiframe loss
// - CRC multiframe loss suspends listed error detectors
// - Basic frame loss forces signalling multiframe loss
// - Pattern error or zero slot16 drops signalling alignment
// - Signalling search restarts only with basic alignment
// - Signalling loss suspends signalling pattern errors
// - International bits captured per frame, held out-of-frame
// - Remote alarm bit captured per NFAS, held
// - National bits captured per NFAS, held
// - Five four-bit national codewords per sub-multiframe
// - De-bounce needs two equal consecutive codewords
// - Codeword register change sets change flag
// - Codeword registers frozen during CRC multiframe loss
// - Spare bits loaded at next signalling multiframe
// - Remote signalling alarm loaded likewise, held
// - Twelve Sa6 bits matched against five codes
// - Aligned mode matches three Sa6 codewords instead
// - Link status on two of three Sa7 zeros
// - Status transitions or events set flags
// - Flags stay set until host clears them
// - Enabled set flag drives interrupt pin
// - Multiframe and sub-multiframe start events flagged
package eros_pkg;

	localparam logic [4:0]  TS0_SLOT    = 5'h00;
	localparam logic [4:0]  TS16_SLOT   = 5'h10;
	localparam logic [4:0]  LAST_SLOT   = 5'h1F;
	localparam logic [2:0]  LAST_BIT    = 3'h7;
	localparam logic [2:0]  FIRST_BIT   = 3'h0;
	localparam logic [2:0]  SUBMF_LAST  = 3'h7;
	localparam logic [3:0]  MF_FIRST    = 4'h0;
	localparam logic [3:0]  SA6_RUN     = 4'hC;
	localparam logic [1:0]  SA7_RUN     = 2'h3;
	localparam int          NUM_CW      = 5;
	localparam int          NUM_CODES   = 5;
	localparam logic [11:0] SA6_CODES [NUM_CODES] = '{12'h888, 12'hAAA, 12'hCCC, 12'hEEE,
		12'hFFF};

	// Flag vector positions
	localparam int F_INTERWORK = 0;
	localparam int F_BASIC     = 1;
	localparam int F_CRCMF     = 2;
	localparam int F_SIGMF     = 3;
	localparam int F_COFA      = 4;
	localparam int F_FAS_ERR   = 5;
	localparam int F_CMF_ERR   = 6;
	localparam int F_SMF_ERR   = 7;
	localparam int F_CRC4      = 8;
	localparam int F_OFFLINE   = 9;
	localparam int F_FEBE      = 10;
	localparam int F_RAICRC    = 11;
	localparam int F_CFEBE     = 12;
	localparam int F_CMF_START = 13;
	localparam int F_SUB_START = 14;
	localparam int F_SMF_START = 15;
	localparam int F_CW_BASE   = 16;
	localparam int F_CODE_BASE = 21;
	localparam int F_NT_FEBE   = 26;
	localparam int F_NT_CRC    = 27;
	localparam int F_LINK      = 28;
	localparam int F_EXCRC     = 29;
	localparam int FLAG_W      = 30;

	// Bit position supplied by the framer
	typedef struct packed {
		logic       bit_strobe;
		logic       data_bit;
		logic [4:0] slot;
		logic [2:0] bit_idx;
		logic [3:0] crc_frame;
		logic [3:0] sig_frame;
	} eros_pos_type;

	// Search results and raw conditions from the framer
	typedef struct packed {
		logic basic_lost;
		logic crc_mf_fail;
		logic crc_mf_found;
		logic sig_mf_found;
		logic offline;
		logic interwork;
		logic raicrc_cond;
		logic cfebe_cond;
	} eros_sync_type;

	// Raw one-cycle error events from the detectors
	typedef struct packed {
		logic fas;
		logic crc_mf;
		logic crc4;
		logic excrc;
		logic febe;
		logic nt_crc;
		logic nt_febe;
		logic cofa;
	} eros_err_type;

	typedef struct packed {
		logic sig_mf_pattern_loss_criterion;
		logic slot16_zero_loss_criterion;
		logic national_codeword_debounce;
		logic code6_subframe_align_select;
	} eros_cfg_type;

	typedef struct packed {
		logic [1:0] si;
		logic       alarm;
		logic [4:0] sa;
		logic [2:0] spare;
		logic       sig_alarm;
	} eros_ovh_type;

	typedef struct packed {
		logic basic_frame_loss_status;
		logic crc_mf_loss_status;
		logic sig_mf_loss_status;
		logic offline_search_status;
		logic crc_noncrc_interwork_status;
		logic alarm_and_block_err_status;
		logic continuous_block_err_status;
		logic link_id_status;
	} eros_stat_type;

endpackage

//--- core/eros_flags.sv
/*
 Sticky indication flags with per-flag enables and one interrupt output.
 Assumes set and clear pulses on the same clock; set wins over clear.
*/
`timescale 1ns/1ps
module eros_flags
#(
	parameter int W = 8
)
(
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] set_pulse,
	input  wire logic [W-1:0] clear_pulse,
	input  wire logic [W-1:0] enable,
	output logic      [W-1:0] flag_reg,
	output logic              irq_reg
);
	logic [W-1:0] flag_next;

	// Set wins over a clear in the same cycle
	assign flag_next = set_pulse | (flag_reg & ~clear_pulse);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			flag_reg <= '0;
		else
			flag_reg <= flag_next;
	end

	// Interrupt from enabled flags
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(flag_next & enable);
	end
endmodule

//--- core/eros_monitor.sv
/*
 E1 receive overhead extraction and multiframe loss monitor.
 Assumes framer inputs on clk_sys; bit_strobe marks one line bit,
 positions and counters are valid with it.
*/
`timescale 1ns/1ps
module eros_monitor
	import eros_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire eros_pos_type           pos,
	input  wire eros_sync_type          sync_in,
	input  wire eros_err_type           err_in,
	input  wire eros_cfg_type           cfg,
	input  wire logic [FLAG_W-1:0]      flag_clear,
	input  wire logic [FLAG_W-1:0]      flag_enable,
	output eros_ovh_type                ovh_reg,
	output logic [NUM_CW-1:0][3:0]      codeword_reg,
	output eros_stat_type               stat_reg,
	output eros_err_type                pm_event_reg,
	output logic                        sig_search_enable_reg,
	output logic [FLAG_W-1:0]           flag_reg,
	output logic                        irq_reg
);
	logic                     ts0_end;
	logic                     ts16_end;
	logic                     frame_start;
	logic [7:0]               slot_byte;
	logic                     is_nfas;
	logic                     basic_ok;
	logic                     sub_end;
	logic [6:0]               shift_reg;
	logic [NUM_CW-1:0][3:0]   asm_reg;
	logic [NUM_CW-1:0][3:0]   asm_next;
	logic [NUM_CW-1:0][3:0]   prev_cw_reg;
	logic [NUM_CW-1:0]        cw_change;
	logic [3:0]               spare_pend_reg;
	logic                     sig_pat_err;
	logic                     sig_zero;
	logic                     crc_lost_next;
	logic                     sig_lost_next;
	logic [11:0]              sa6_bits_reg;
	logic [3:0]               sa6_cnt_reg;
	logic [11:0]              sa6_cw_hist_reg;
	logic [1:0]               sa6_cw_cnt_reg;
	logic [11:0]              sa6_bits_next;
	logic [11:0]              sa6_cw_next;
	logic [NUM_CODES-1:0]     code_hit;
	logic [2:0]               sa7_bits_reg;
	logic [1:0]               sa7_cnt_reg;
	logic [2:0]               sa7_next;
	logic                     link_next;
	eros_stat_type            stat_next;
	logic [FLAG_W-1:0]        flag_set;

	// Bit position decode
	assign ts0_end     = pos.bit_strobe && pos.slot == TS0_SLOT && pos.bit_idx == LAST_BIT;
	assign ts16_end    = pos.bit_strobe && pos.slot == TS16_SLOT && pos.bit_idx == LAST_BIT;
	assign frame_start = pos.bit_strobe && pos.slot == TS0_SLOT && pos.bit_idx == FIRST_BIT;
	assign slot_byte   = {shift_reg, pos.data_bit};
	assign is_nfas     = slot_byte[6];
	assign basic_ok    = !sync_in.basic_lost;
	assign sub_end     = ts0_end && is_nfas && pos.crc_frame[2:0] == SUBMF_LAST;

	// Slot byte shifter, first received bit ends up as MSB
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			shift_reg <= 7'h00;
		else if (pos.bit_strobe)
			shift_reg <= {shift_reg[5:0], pos.data_bit};
	end

	// CRC multiframe loss follows basic loss or failed search
	always_comb
	begin
		crc_lost_next = stat_reg.crc_mf_loss_status;
		if (sync_in.basic_lost || sync_in.crc_mf_fail)
			crc_lost_next = 1'b1;
		else if (sync_in.crc_mf_found)
			crc_lost_next = 1'b0;
	end

	// Signalling multiframe alignment check in slot 16
	assign sig_pat_err = ts16_end && pos.sig_frame == MF_FIRST && slot_byte[7:4] != 4'h0
		&& !stat_reg.sig_mf_loss_status;
	assign sig_zero    = ts16_end && slot_byte == 8'h00;

	always_comb
	begin
		sig_lost_next = stat_reg.sig_mf_loss_status;
		if (sync_in.basic_lost)
			sig_lost_next = 1'b1;
		else if ((cfg.sig_mf_pattern_loss_criterion && sig_pat_err)
			|| (cfg.slot16_zero_loss_criterion && sig_zero))
			sig_lost_next = 1'b1;
		else if (sync_in.sig_mf_found && sig_search_enable_reg)
			sig_lost_next = 1'b0;
	end

	// Status bits
	always_comb
	begin
		stat_next = stat_reg;
		stat_next.basic_frame_loss_status     = sync_in.basic_lost;
		stat_next.crc_mf_loss_status          = crc_lost_next;
		stat_next.sig_mf_loss_status          = sig_lost_next;
		stat_next.offline_search_status       = sync_in.offline;
		stat_next.crc_noncrc_interwork_status = sync_in.interwork;
		stat_next.alarm_and_block_err_status  = sync_in.raicrc_cond && !crc_lost_next;
		stat_next.continuous_block_err_status = sync_in.cfebe_cond && !crc_lost_next;
		stat_next.link_id_status              = link_next;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			stat_reg <= '{crc_mf_loss_status: 1'b1, sig_mf_loss_status: 1'b1,
				basic_frame_loss_status: 1'b1, default: 1'b0};
		else
			stat_reg <= stat_next;
	end

	// Signalling search allowed only with basic alignment
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			sig_search_enable_reg <= 1'b0;
		else
			sig_search_enable_reg <= sig_lost_next && basic_ok;
	end

	// Error events other than cofa forwarded only while CRC multiframe alignment holds
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			pm_event_reg <= '0;
		else if (stat_reg.crc_mf_loss_status)
			pm_event_reg <= '{cofa: err_in.cofa, default: 1'b0};
		else
			pm_event_reg <= err_in;
	end

	// TS0 bits per frame; TS16 spare bits wait for the next multiframe start
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			ovh_reg        <= '0;
			spare_pend_reg <= 4'h0;
		end
		else
		begin
			if (ts0_end && basic_ok && is_nfas)
			begin
				ovh_reg.si[1] <= slot_byte[7];
				ovh_reg.alarm <= slot_byte[5];
				ovh_reg.sa    <= slot_byte[4:0];
			end
			if (ts0_end && basic_ok && !is_nfas)
				ovh_reg.si[0] <= slot_byte[7];
			if (ts16_end && pos.sig_frame == MF_FIRST && !stat_reg.sig_mf_loss_status)
				spare_pend_reg <= slot_byte[3:0];
			if (frame_start && pos.sig_frame == MF_FIRST && !stat_reg.sig_mf_loss_status)
			begin
				ovh_reg.spare     <= {spare_pend_reg[3], spare_pend_reg[1:0]};
				ovh_reg.sig_alarm <= spare_pend_reg[2];
			end
		end
	end

	// Codeword assembly, one bit per NFAS frame for each Sa bit
	always_comb
	begin
		for (int i = 0; i < NUM_CW; i++)
			asm_next[i] = {asm_reg[i][2:0], slot_byte[NUM_CW-1-i]};
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			asm_reg <= '0;
		else if (ts0_end && is_nfas && !stat_reg.crc_mf_loss_status)
			asm_reg <= asm_next;
	end

	// Codeword registers with optional de-bounce
	always_comb
	begin
		for (int i = 0; i < NUM_CW; i++)
			cw_change[i] = sub_end && !stat_reg.crc_mf_loss_status
				&& (!cfg.national_codeword_debounce || asm_next[i] == prev_cw_reg[i])
				&& asm_next[i] != codeword_reg[i];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			prev_cw_reg  <= '0;
			codeword_reg <= '0;
		end
		else if (sub_end && !stat_reg.crc_mf_loss_status)
		begin
			prev_cw_reg <= asm_next;
			for (int i = 0; i < NUM_CW; i++)
				if (cw_change[i])
					codeword_reg[i] <= asm_next[i];
		end
	end

	// Sa6 run of twelve bits and run of three codewords
	assign sa6_bits_next = {sa6_bits_reg[10:0], slot_byte[2]};
	assign sa6_cw_next   = {sa6_cw_hist_reg[7:0], asm_next[2]};

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b || sync_in.basic_lost)
		begin
			sa6_bits_reg <= 12'h000;
			sa6_cnt_reg  <= 4'h0;
		end
		else if (ts0_end && is_nfas)
		begin
			sa6_bits_reg <= sa6_bits_next;
			if (sa6_cnt_reg != SA6_RUN)
				sa6_cnt_reg <= sa6_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b || stat_reg.crc_mf_loss_status)
		begin
			sa6_cw_hist_reg <= 12'h000;
			sa6_cw_cnt_reg  <= 2'h0;
		end
		else if (sub_end)
		begin
			sa6_cw_hist_reg <= sa6_cw_next;
			if (sa6_cw_cnt_reg != 2'h3)
				sa6_cw_cnt_reg <= sa6_cw_cnt_reg + 2'h1;
		end
	end

	// Code comparison, codeword mode when aligned and selected
	always_comb
	begin
		for (int i = 0; i < NUM_CODES; i++)
		begin
			if (cfg.code6_subframe_align_select && !stat_reg.crc_mf_loss_status)
				code_hit[i] = sub_end && sa6_cw_cnt_reg >= 2'h2
					&& sa6_cw_next == SA6_CODES[i];
			else
				code_hit[i] = ts0_end && is_nfas && basic_ok
					&& sa6_cnt_reg >= SA6_RUN - 4'h1
					&& sa6_bits_next == SA6_CODES[i];
		end
	end

	// Sliding window of three Sa7 bits
	assign sa7_next = {sa7_bits_reg[1:0], slot_byte[1]};

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b || sync_in.basic_lost)
		begin
			sa7_bits_reg <= 3'h7;
			sa7_cnt_reg  <= 2'h0;
		end
		else if (ts0_end && is_nfas)
		begin
			sa7_bits_reg <= sa7_next;
			if (sa7_cnt_reg != SA7_RUN)
				sa7_cnt_reg <= sa7_cnt_reg + 2'h1;
		end
	end

	// Two zeros among three bits, only with basic alignment
	always_comb
	begin
		link_next = stat_reg.link_id_status;
		if (sync_in.basic_lost)
			link_next = 1'b0;
		else if (ts0_end && is_nfas && sa7_cnt_reg >= SA7_RUN - 2'h1)
			link_next = (2'(!sa7_next[0]) + 2'(!sa7_next[1]) + 2'(!sa7_next[2])) >= 2'h2;
	end

	// Flag sources: status transitions and direct events
	always_comb
	begin
		flag_set = '0;
		flag_set[F_INTERWORK] = stat_next.crc_noncrc_interwork_status
			!= stat_reg.crc_noncrc_interwork_status;
		flag_set[F_BASIC]     = stat_next.basic_frame_loss_status
			!= stat_reg.basic_frame_loss_status;
		flag_set[F_CRCMF]     = stat_next.crc_mf_loss_status != stat_reg.crc_mf_loss_status;
		flag_set[F_SIGMF]     = stat_next.sig_mf_loss_status != stat_reg.sig_mf_loss_status;
		flag_set[F_OFFLINE]   = stat_next.offline_search_status
			!= stat_reg.offline_search_status;
		flag_set[F_RAICRC]    = stat_next.alarm_and_block_err_status
			!= stat_reg.alarm_and_block_err_status;
		flag_set[F_CFEBE]     = stat_next.continuous_block_err_status
			!= stat_reg.continuous_block_err_status;
		flag_set[F_LINK]      = stat_next.link_id_status != stat_reg.link_id_status;
		flag_set[F_COFA]      = err_in.cofa;
		flag_set[F_FAS_ERR]   = err_in.fas && !stat_reg.crc_mf_loss_status;
		flag_set[F_CMF_ERR]   = err_in.crc_mf && !stat_reg.crc_mf_loss_status;
		flag_set[F_CRC4]      = err_in.crc4 && !stat_reg.crc_mf_loss_status;
		flag_set[F_EXCRC]     = err_in.excrc && !stat_reg.crc_mf_loss_status;
		flag_set[F_FEBE]      = err_in.febe && !stat_reg.crc_mf_loss_status;
		flag_set[F_NT_FEBE]   = err_in.nt_febe && !stat_reg.crc_mf_loss_status;
		flag_set[F_NT_CRC]    = err_in.nt_crc && !stat_reg.crc_mf_loss_status;
		flag_set[F_SMF_ERR]   = sig_pat_err;
		flag_set[F_CMF_START] = frame_start && pos.crc_frame == MF_FIRST
			&& !stat_reg.crc_mf_loss_status;
		flag_set[F_SUB_START] = frame_start && pos.crc_frame[2:0] == 3'h0
			&& !stat_reg.crc_mf_loss_status;
		flag_set[F_SMF_START] = frame_start && pos.sig_frame == MF_FIRST
			&& !stat_reg.sig_mf_loss_status;
		flag_set[F_CW_BASE +: NUM_CW]      = cw_change;
		flag_set[F_CODE_BASE +: NUM_CODES] = code_hit;
	end

	// Sticky flags and interrupt
	eros_flags
	#(
		.W(FLAG_W)
	)
	u_flags
	(
		.clk_sys     (clk_sys),
		.rst_b       (rst_b),
		.set_pulse   (flag_set),
		.clear_pulse (flag_clear),
		.enable      (flag_enable),
		.flag_reg    (flag_reg),
		.irq_reg     (irq_reg)
	);
endmodule

//--- verification/eros_monitor_chk.sv
/*
 Port checker for eros_monitor.
 Bound to the monitor; sees its ports only, one clock domain.
*/
`timescale 1ns/1ps
module eros_monitor_chk
	import eros_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   rst_b,
	input wire eros_pos_type           pos,
	input wire eros_sync_type          sync_in,
	input wire eros_err_type           err_in,
	input wire eros_cfg_type           cfg,
	input wire logic [FLAG_W-1:0]      flag_clear,
	input wire logic [FLAG_W-1:0]      flag_enable,
	input wire eros_ovh_type           ovh_reg,
	input wire logic [NUM_CW-1:0][3:0] codeword_reg,
	input wire eros_stat_type          stat_reg,
	input wire eros_err_type           pm_event_reg,
	input wire logic                   sig_search_enable_reg,
	input wire logic [FLAG_W-1:0]      flag_reg,
	input wire logic                   irq_reg
);
	logic [FLAG_W-1:0] kept_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Flags set and not cleared last cycle must still be set
	always_ff @(posedge clk_sys)
	begin
		kept_reg <= rst_b ? (flag_reg & ~flag_clear) : '0;
	end

	sequence basic_drop;
		sync_in.basic_lost;
	endsequence
	sequence crc_mf_begin;
		pos.bit_strobe && pos.slot == TS0_SLOT && pos.bit_idx == FIRST_BIT &&
			pos.crc_frame == MF_FIRST && !stat_reg.crc_mf_loss_status && !sync_in.basic_lost;
	endsequence

	AST_CRC_FORCED: assert property (basic_drop |=> stat_reg.crc_mf_loss_status)
		else $error("crc multiframe loss not declared with basic loss");
	AST_SIG_FORCED: assert property (basic_drop |=> stat_reg.sig_mf_loss_status
		&& !sig_search_enable_reg) else $error("signalling loss or search wrong on basic loss");
	AST_SUSPEND: assert property (basic_drop ##0 stat_reg.crc_mf_loss_status
		|=> (pm_event_reg & 8'hFE) == 8'h00) else $error("error event passed during crc loss");
	AST_OVH_HOLD: assert property (basic_drop |=> $stable(ovh_reg.si) &&
		$stable(ovh_reg.alarm) && $stable(ovh_reg.sa)) else $error("frame bits moved out of frame");
	AST_CW_FREEZE: assert property (basic_drop ##0 stat_reg.crc_mf_loss_status
		|=> $stable(codeword_reg)) else $error("codeword moved during crc loss");
	AST_FLAG_STICKY: assert property ((kept_reg & ~flag_reg) == '0)
		else $error("flag dropped without clear");
	AST_LINK_EDGE: assert property ($changed(stat_reg.link_id_status) |-> flag_reg[F_LINK])
		else $error("link status edge without flag");
	AST_IRQ_SUM: assert property ($stable(flag_enable) |->
		irq_reg == |(flag_reg & flag_enable)) else $error("irq not or of enabled flags");
	AST_CMF_START: assert property (crc_mf_begin |=> flag_reg[F_CMF_START])
		else $error("crc multiframe start not flagged");
endmodule

//--- verification/eros_line_model.sv
/*
 Line model: E1 bit stream with framer positions for eros_monitor.
 Drives on the falling edge; slow gives one bit every other cycle.
*/
`timescale 1ns/1ps
module eros_line_model
	import eros_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       slow,
	input  wire logic [1:0] si,
	input  wire logic       alarm,
	input  wire logic [4:0] sa,
	input  wire logic [2:0] spare,
	input  wire logic       sig_alarm,
	output eros_pos_type    pos
);
	logic [11:0] count_reg;
	logic        idle_reg;

	// Bit at frame, slot, bit position; other slots carry noise
	function automatic logic pick(input logic [11:0] c);
		logic [7:0] b;
		if (c[7:3] == TS0_SLOT)
			b = c[8] ? {si[1], 1'b1, alarm, sa} : {si[0], 7'h1B};
		else if (c[7:3] == TS16_SLOT && c[11:8] == MF_FIRST)
			b = {4'h0, spare[2], sig_alarm, spare[1:0]};
		else
			b = 8'($urandom);
		return b[3'h7 - c[2:0]];
	endfunction

	// Stream advance; between slow bits the data line toggles
	always @(negedge clk_sys)
	begin
		if (!rst_b)
		begin
			count_reg <= 12'h000;
			idle_reg  <= 1'b0;
			pos       <= '0;
		end
		else if (slow && !idle_reg)
		begin
			idle_reg       <= 1'b1;
			pos.bit_strobe <= 1'b0;
			pos.data_bit   <= ~pos.data_bit;
		end
		else
		begin
			idle_reg  <= 1'b0;
			pos       <= {1'b1, pick(count_reg), count_reg[7:0], count_reg[11:8], count_reg[11:8]};
			count_reg <= count_reg + 12'h001;
		end
	end
endmodule

//--- verification/eros_monitor_bench.sv
/*
 Self-checking bench for eros_monitor with queued expectations.
 Assumes eros_line_model as framer stream and the bound checker.
*/
`timescale 1ns/1ps
module eros_monitor_bench
	import eros_pkg::*;
();
	logic                   clk_sys;
	logic                   rst_b;
	logic                   slow;
	logic [1:0]             si_v;
	logic                   alarm_v;
	logic [4:0]             sa_v;
	logic [4:0]             chg;
	logic [4:0]             m;
	logic [2:0]             spare_v;
	logic                   y_v;
	logic [5:0]             seen_ovh;
	logic [19:0]            seen_cw;
	logic [19:0]            old_cw;
	logic [7:0]             e;
	eros_pos_type           pos;
	eros_sync_type          sync_in;
	eros_err_type           err_in;
	eros_cfg_type           cfg;
	logic [FLAG_W-1:0]      flag_clear;
	logic [FLAG_W-1:0]      flag_enable;
	eros_ovh_type           ovh_reg;
	logic [NUM_CW-1:0][3:0] codeword_reg;
	eros_stat_type          stat_reg;
	eros_err_type           pm_event_reg;
	logic                   sig_search_enable_reg;
	logic [FLAG_W-1:0]      flag_reg;
	logic                   irq_reg;
	logic [5:0]             ovh_q[$];
	logic [19:0]            cw_q[$];
	int                     bad_count;
	int                     checked;

	eros_monitor i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .pos(pos), .sync_in(sync_in),
		.err_in(err_in), .cfg(cfg), .flag_clear(flag_clear), .flag_enable(flag_enable),
		.ovh_reg(ovh_reg), .codeword_reg(codeword_reg), .stat_reg(stat_reg),
		.pm_event_reg(pm_event_reg), .sig_search_enable_reg(sig_search_enable_reg),
		.flag_reg(flag_reg), .irq_reg(irq_reg));
	eros_line_model i_line (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .si(si_v),
		.alarm(alarm_v), .sa(sa_v), .spare(spare_v), .sig_alarm(y_v), .pos(pos));

	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Wait for n sub-multiframe starts, then step to the falling edge
	task wait_sub(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			while (!(pos.bit_strobe && pos.slot == TS0_SLOT && pos.bit_idx == FIRST_BIT &&
				pos.crc_frame[2:0] == 3'h0))
				@(posedge clk_sys);
		end
		@(negedge clk_sys);
	endtask

	// New national bits; notes the register values they must produce
	task set_ovh(input logic [4:0] s, input logic a);
		if ({a, s} !== {alarm_v, sa_v})
			ovh_q.push_back({a, s});
		if (s !== sa_v)
			cw_q.push_back({{4{s[0]}}, {4{s[1]}}, {4{s[2]}}, {4{s[3]}}, {4{s[4]}}});
		chg     = chg | (s ^ sa_v);
		sa_v    = s;
		alarm_v = a;
	endtask

	// Output watcher: each register change takes the oldest note
	always @(posedge clk_sys)
	begin
		#1;
		if (rst_b === 1'b1 && {ovh_reg.alarm, ovh_reg.sa} !== seen_ovh)
		begin
			seen_ovh = {ovh_reg.alarm, ovh_reg.sa};
			check(32'(seen_ovh), ovh_q.size() > 0 ? 32'(ovh_q.pop_front()) : 32'hFFFFFFFF);
		end
		if (rst_b === 1'b1 && codeword_reg !== seen_cw)
		begin
			seen_cw = codeword_reg;
			check(32'(seen_cw), cw_q.size() > 0 ? 32'(cw_q.pop_front()) : 32'hFFFFFFFF);
		end
	end

	// Hang guard
	initial
	begin
		repeat (80000) @(posedge clk_sys);
		bad_count++;
		end_of_test;
	end

	// Test sequence
	initial
	begin
		{clk_sys, rst_b, slow, si_v, alarm_v, sa_v, chg, spare_v, y_v} = '0;
		{seen_ovh, seen_cw, bad_count, checked} = '0;
		sync_in = 8'h80;
		{err_in, cfg, flag_clear, flag_enable} = '0;
		void'($urandom(32'h1C8F));
		repeat (16) @(negedge clk_sys);
		rst_b = 1'b1;
		err_in = 8'hFF;
		@(negedge clk_sys);
		err_in = 8'h00;
		check(stat_reg, 8'hE0);
		check(pm_event_reg, 8'h01);
		@(negedge clk_sys);
		check({flag_reg[F_COFA], flag_reg[F_CRC4], flag_reg[F_FEBE], irq_reg, sig_search_enable_reg}, 5'b10000);
		$display("test reset and suspension done");
		sync_in.basic_lost = 1'b0;
		wait_sub(1);
		{sync_in.crc_mf_found, sync_in.sig_mf_found} = 2'b11;
		wait_sub(1);
		e = 8'($urandom);
		err_in = e;
		@(negedge clk_sys);
		err_in = 8'h00;
		check(pm_event_reg, e);
		for (int k = 0; k < 3; k++)
		begin
			cfg.national_codeword_debounce = (k == 2);
			wait_sub(1);
			old_cw = codeword_reg;
			{spare_v, y_v, si_v} = 6'($urandom);
			set_ovh(sa_v ^ 5'($urandom_range(31, 1)), 1'($urandom));
			wait_sub(1);
			if (k == 2)
				check(codeword_reg, old_cw);
			wait_sub(3);
			check({ovh_reg.si, ovh_reg.spare, ovh_reg.sig_alarm}, {si_v, spare_v, y_v});
		end
		$display("test overhead capture done");
		for (int i = 0; i < NUM_CW; i++)
			m[i] = chg[4 - i];
		check(flag_reg[F_CW_BASE +: NUM_CW], m);
		flag_enable[F_CW_BASE +: NUM_CW] = m;
		repeat (2) @(negedge clk_sys);
		check(irq_reg, 1);
		flag_clear[F_CW_BASE +: NUM_CW] = m;
		@(negedge clk_sys);
		flag_clear = '0;
		@(negedge clk_sys);
		check({flag_reg[F_CW_BASE +: NUM_CW], irq_reg}, 0);
		$display("test flags and irq done");
		slow = 1'b1;
		cfg.code6_subframe_align_select = 1'b1;
		set_ovh(5'b00100, 1'b0);
		wait_sub(1);
		flag_clear = '1;
		@(negedge clk_sys);
		flag_clear = '0;
		wait_sub(3);
		check(flag_reg[F_CODE_BASE +: NUM_CODES], 5'b10000);
		check({stat_reg.link_id_status, flag_reg[F_LINK]}, 2'b10);
		// Twelve-bit mode: the Sa6 run of ones must match the all-ones code
		cfg.code6_subframe_align_select = 1'b0;
		flag_clear = '1;
		@(negedge clk_sys);
		flag_clear = '0;
		wait_sub(1);
		check(flag_reg[F_CODE_BASE +: NUM_CODES], 5'b10000);
		$display("test code and link done");
		sync_in.basic_lost = 1'b1;
		repeat (2) @(negedge clk_sys);
		check({stat_reg[7:5], sig_search_enable_reg, stat_reg.link_id_status}, 5'b11100);
		check(flag_reg[F_BASIC], 1);
		wait_sub(2);
		check(ovh_q.size() + cw_q.size(), 0);
		$display("test frame loss done");
		end_of_test;
	end
endmodule

bind eros_monitor eros_monitor_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .pos(pos),
	.sync_in(sync_in), .err_in(err_in), .cfg(cfg), .flag_clear(flag_clear),
	.flag_enable(flag_enable), .ovh_reg(ovh_reg), .codeword_reg(codeword_reg),
	.stat_reg(stat_reg), .pm_event_reg(pm_event_reg),
	.sig_search_enable_reg(sig_search_enable_reg), .flag_reg(flag_reg), .irq_reg(irq_reg));
